// [anr_pkg.sv]
// constants for the autonegotiation ability register block
// assumes a clause 45 frame engine outside decodes device and register addresses
package anr_pkg;
    // ****************************************
    // addressing
    // ****************************************
    localparam logic [4:0] DEVAD_AN = 5'h07;
    localparam logic [15:0] ADDR_LOCAL_ADV_UPPER = 16'h0204;
    localparam logic [15:0] ADDR_PARTNER_LOWER = 16'h0205;
    localparam logic [15:0] ADDR_PARTNER_MIDDLE = 16'h0206;
    localparam logic [15:0] ADDR_PARTNER_HIGH = 16'h0207;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_HI_ABL = 13;
    localparam int BIT_HI_REQ = 12;
    localparam int BIT_LP_NEXT_PAGE = 15;
    localparam int BIT_LP_ACK = 14;
    localparam int BIT_LP_REMOTE_FAULT = 13;
    localparam int BIT_LP_ROLE_FORCED = 12;
    localparam int BIT_LP_PAUSE_LO = 10;
    localparam int BIT_LP_ROLE = 4;

    // ****************************************
    // values after reset and fixed values
    // ****************************************
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [4:0] SELECTOR_STD = 5'h01;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage : anr_pkg

// [anr_ability_regs.sv]
// autonegotiation local upper advertisement word, partner base page words,
// and transmit amplitude resolution
// assumes decoded clause 45 register accesses arrive as one-cycle strobes on clk_sys,
// partner page fields come from negotiation logic on the same clock,
// strap pins are asynchronous
`timescale 1ns/1ps
module anr_ability_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register access
    input wire logic [4:0] reg_devad,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_r,
    output logic reg_rd_valid_r,
    // configuration pins
    input wire logic strap_high_amplitude_capable,
    input wire logic strap_high_amplitude_request,
    // partner base page from negotiation logic
    input wire logic partner_page_received,
    input wire logic partner_next_page_request,
    input wire logic partner_acknowledge,
    input wire logic partner_remote_fault,
    input wire logic partner_role_forced,
    input wire logic [1:0] partner_pause_ability,
    input wire logic [15:0] partner_middle_live,
    input wire logic [15:0] partner_high_live,
    // resolved state
    output logic local_high_amplitude_capable_r,
    output logic local_high_amplitude_request_r,
    output logic tx_high_level_r
);

    // ****************************************
    // strap synchronisers and settle counter
    // ****************************************
    logic [1:0] strap_meta_r;
    logic [1:0] strap_sync_r;
    logic [1:0] strap_cnt_r;
    logic strap_busy;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_meta_r <= 2'h0;
            strap_sync_r <= 2'h0;
        end
        else
        begin
            strap_meta_r <= {strap_high_amplitude_capable, strap_high_amplitude_request};
            strap_sync_r <= strap_meta_r;
        end
    end

    assign strap_busy = (strap_cnt_r != anr_pkg::STRAP_SETTLE);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            strap_cnt_r <= 2'h0;
        else if (strap_busy)
            strap_cnt_r <= strap_cnt_r + 2'h1;
    end

    // ****************************************
    // access decode
    // ****************************************
    logic dev_hit;
    logic wr_local;
    logic rd_lower;

    assign dev_hit = (reg_devad == anr_pkg::DEVAD_AN);
    assign wr_local = reg_wr_stb && dev_hit && (reg_addr == anr_pkg::ADDR_LOCAL_ADV_UPPER);
    assign rd_lower = reg_rd_stb && dev_hit && (reg_addr == anr_pkg::ADDR_PARTNER_LOWER);

    // ****************************************
    // local advertisement upper word
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            local_high_amplitude_capable_r <= 1'b0;
            local_high_amplitude_request_r <= 1'b0;
        end
        else if (strap_busy)
        begin
            local_high_amplitude_capable_r <= strap_sync_r[1];
            local_high_amplitude_request_r <= strap_sync_r[0];
        end
        else if (wr_local)
        begin
            // only bits 13 and 12 are stored; others are dropped
            local_high_amplitude_capable_r <= reg_wdata[anr_pkg::BIT_HI_ABL];
            local_high_amplitude_request_r <= reg_wdata[anr_pkg::BIT_HI_REQ];
        end
    end

    // ****************************************
    // partner snapshot of middle and high words
    // ****************************************
    logic [15:0] partner_middle_hold_r;
    logic [15:0] partner_high_hold_r;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            partner_middle_hold_r <= anr_pkg::RST_WORD;
            partner_high_hold_r <= anr_pkg::RST_WORD;
        end
        else if (rd_lower)
        begin
            // middle word bit 4 carries the partner role, 1 leader
            partner_middle_hold_r <= partner_middle_live;
            partner_high_hold_r <= partner_high_live;
        end
    end

    // ****************************************
    // transmit amplitude resolution
    // ****************************************
    logic both_capable;
    logic any_request;
    logic tx_high_level_nxt;

    assign both_capable = local_high_amplitude_capable_r && partner_high_live[anr_pkg::BIT_HI_ABL];
    assign any_request = local_high_amplitude_request_r || partner_high_live[anr_pkg::BIT_HI_REQ];

    always_comb
    begin
        if (!both_capable)
            tx_high_level_nxt = 1'b0;
        else if (any_request)
            tx_high_level_nxt = 1'b1;
        else
            tx_high_level_nxt = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            tx_high_level_r <= 1'b0;
        else
            tx_high_level_r <= tx_high_level_nxt;
    end

    // ****************************************
    // read data
    // ****************************************
    logic [15:0] local_word;
    logic [15:0] lower_word;
    logic [15:0] rdata_nxt;

    always_comb
    begin
        local_word = anr_pkg::RST_WORD;
        local_word[anr_pkg::BIT_HI_ABL] = local_high_amplitude_capable_r;
        local_word[anr_pkg::BIT_HI_REQ] = local_high_amplitude_request_r;
    end

    always_comb
    begin
        lower_word = anr_pkg::RST_WORD;
        lower_word[anr_pkg::BIT_LP_NEXT_PAGE] = partner_next_page_request;
        lower_word[anr_pkg::BIT_LP_ACK] = partner_acknowledge;
        lower_word[anr_pkg::BIT_LP_REMOTE_FAULT] = partner_remote_fault;
        lower_word[anr_pkg::BIT_LP_ROLE_FORCED] = partner_role_forced;
        lower_word[anr_pkg::BIT_LP_PAUSE_LO+1 -: 2] = partner_pause_ability;
        if (partner_page_received)
            lower_word[4:0] = anr_pkg::SELECTOR_STD;
    end

    always_comb
    begin
        rdata_nxt = anr_pkg::RST_WORD;
        unique case (reg_addr)
            anr_pkg::ADDR_LOCAL_ADV_UPPER: rdata_nxt = local_word;
            anr_pkg::ADDR_PARTNER_LOWER: rdata_nxt = lower_word;
            anr_pkg::ADDR_PARTNER_MIDDLE: rdata_nxt = partner_middle_hold_r;
            anr_pkg::ADDR_PARTNER_HIGH: rdata_nxt = partner_high_hold_r;
            default: rdata_nxt = anr_pkg::RST_WORD;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_r <= anr_pkg::RST_WORD;
            reg_rd_valid_r <= 1'b0;
        end
        else
        begin
            reg_rd_valid_r <= reg_rd_stb && dev_hit;
            if (reg_rd_stb && dev_hit)
                reg_rdata_r <= rdata_nxt;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    chk_abl_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_local && !strap_busy) |=> (local_high_amplitude_capable_r == $past(reg_wdata[13])))
        else $error("capable bit not taken from write");

    chk_req_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_local && !strap_busy) |=> (local_high_amplitude_request_r == $past(reg_wdata[12])))
        else $error("request bit not taken from write");

    chk_strap_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        strap_busy |=> ({local_high_amplitude_capable_r, local_high_amplitude_request_r}
         == $past(strap_sync_r)))
        else $error("local bits not loaded from straps");

    chk_foreign_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_wr_stb && !dev_hit && !strap_busy) |=> ($stable(local_high_amplitude_capable_r)
         && $stable(local_high_amplitude_request_r)))
        else $error("write to other device changed local bits");

    chk_low_not_capable: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(local_high_amplitude_capable_r && partner_high_live[13]) |=> !tx_high_level_r)
        else $error("high level without both capable");

    chk_high_on_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (local_high_amplitude_capable_r && partner_high_live[13]
         && (local_high_amplitude_request_r || partner_high_live[12])) |=> tx_high_level_r)
        else $error("high level not selected");

    chk_low_no_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (local_high_amplitude_capable_r && partner_high_live[13]
         && !local_high_amplitude_request_r && !partner_high_live[12]) |=> !tx_high_level_r)
        else $error("high level without request");

    chk_local_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd_stb && dev_hit && reg_addr == 16'h0204) |=> (reg_rd_valid_r
         && reg_rdata_r == {2'b00, $past(local_high_amplitude_capable_r),
         $past(local_high_amplitude_request_r), 12'h000}))
        else $error("local upper word readback wrong");

    chk_lower_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (rd_lower) |=> (reg_rdata_r[9:5] == 5'h00
         && reg_rdata_r[15] == $past(partner_next_page_request)))
        else $error("lower word reserved or next page wrong");

    chk_lower_status: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        rd_lower |=> (reg_rdata_r[15] == $past(partner_next_page_request)
         && reg_rdata_r[14] == $past(partner_acknowledge)
         && reg_rdata_r[13] == $past(partner_remote_fault)
         && reg_rdata_r[12] == $past(partner_role_forced)))
        else $error("partner status bits wrong");

    chk_lower_pause: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_lower |=> (reg_rdata_r[11:10] == $past(partner_pause_ability)))
        else $error("partner pause bits wrong");

    chk_snapshot_take: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_lower |=> (partner_middle_hold_r == $past(partner_middle_live)
         && partner_high_hold_r == $past(partner_high_live)))
        else $error("snapshot not captured");

    chk_hold_steady: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !rd_lower |=> ($stable(partner_middle_hold_r) && $stable(partner_high_hold_r)))
        else $error("snapshot moved without lower read");

    chk_middle_snapshot: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd_stb && dev_hit && reg_addr == 16'h0206)
         |=> (reg_rdata_r == $past(partner_middle_hold_r)))
        else $error("middle read not from snapshot");

    chk_high_snapshot: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd_stb && dev_hit && reg_addr == 16'h0207)
         |=> (reg_rdata_r == $past(partner_high_hold_r)))
        else $error("high read not from snapshot");

    chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd_stb && dev_hit && (reg_addr < 16'h0204 || reg_addr > 16'h0207))
         |=> (reg_rd_valid_r && reg_rdata_r == 16'h0000))
        else $error("unmapped read not zero");

    chk_selector_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_lower |=> (reg_rdata_r[4:0] == ($past(partner_page_received) ? 5'h01 : 5'h00)))
        else $error("selector field wrong");

endmodule : anr_ability_regs

// [anr_partner_model.sv]
// partner page source standing in for the negotiation logic
// assumes the bench loads a page image away from the rising edge
`timescale 1ns/1ps
module anr_partner_model (
    // clock
    input wire logic clk_sys,
    // page image from the bench
    input wire logic pg_ok,
    input wire logic [15:0] pg_lo,
    input wire logic [15:0] pg_mid,
    input wire logic [15:0] pg_hi,
    // live fields toward the block
    output logic page_rx,
    output logic [5:0] lo_flds,
    output logic [15:0] mid_live,
    output logic [15:0] hi_live
);
    // fields change just after the edge
    always_ff @(posedge clk_sys)
    begin
        page_rx <= pg_ok;
        lo_flds <= pg_lo[15:10];
        mid_live <= pg_mid;
        hi_live <= pg_hi;
    end
endmodule : anr_partner_model

// [tb_anr_ability_regs.sv]
// self-checking bench for the ability register block
// assumes the partner model feeds the partner page inputs
`timescale 1ns/1ps
module tb_anr_ability_regs;
    logic clk_sys, rst_n, wr, rd, s_cap, s_req, pg_ok, vld, prx, rv, lc, lr, txh;
    logic [4:0] devad;
    logic [5:0] flds;
    logic [15:0] addr, wdata, rdata, pg_lo, pg_mid, pg_hi, got, mid, hi;
    int fails, n_tests;

    anr_ability_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_devad(devad),
        .reg_addr(addr), .reg_wr_stb(wr), .reg_rd_stb(rd), .reg_wdata(wdata),
        .reg_rdata_r(rdata), .reg_rd_valid_r(rv), .strap_high_amplitude_capable(s_cap),
        .strap_high_amplitude_request(s_req), .partner_page_received(prx),
        .partner_next_page_request(flds[5]), .partner_acknowledge(flds[4]),
        .partner_remote_fault(flds[3]), .partner_role_forced(flds[2]),
        .partner_pause_ability(flds[1:0]), .partner_middle_live(mid),
        .partner_high_live(hi), .local_high_amplitude_capable_r(lc),
        .local_high_amplitude_request_r(lr), .tx_high_level_r(txh));
    anr_partner_model i_far (.clk_sys(clk_sys), .pg_ok(pg_ok), .pg_lo(pg_lo),
        .pg_mid(pg_mid), .pg_hi(pg_hi), .page_rx(prx), .lo_flds(flds),
        .mid_live(mid), .hi_live(hi));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one strobe, then a bounded watch for the read answer
    task automatic acc(input logic w, input logic [4:0] dv, input logic [15:0] a,
        input logic [15:0] d);
        devad = dv;
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge clk_sys);
        wr = 1'b0;
        rd = 1'b0;
        vld = 1'b0;
        repeat (3)
        begin
            if (!w && rv === 1'b1)
            begin
                vld = 1'b1;
                got = rdata;
            end
            @(negedge clk_sys);
        end
        if (!w && !vld && dv == anr_pkg::DEVAD_AN)
        begin
            fails++;
            close_out();
        end
    endtask : acc

    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        acc(1'b0, anr_pkg::DEVAD_AN, a, 16'h0000);
        chk(got, exp);
    endtask : rdc

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chk({14'h0000, lc, lr}, 16'h0002);
        rdc(anr_pkg::ADDR_LOCAL_ADV_UPPER, 16'h2000);
        rdc(anr_pkg::ADDR_PARTNER_LOWER, 16'h0000);
        rdc(anr_pkg::ADDR_PARTNER_HIGH, 16'h0000);
        rdc(16'h0208, 16'h0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_write();
        acc(1'b1, anr_pkg::DEVAD_AN, anr_pkg::ADDR_LOCAL_ADV_UPPER, 16'hffff);
        rdc(anr_pkg::ADDR_LOCAL_ADV_UPPER, 16'h3000);
        acc(1'b1, 5'h01, anr_pkg::ADDR_LOCAL_ADV_UPPER, 16'h0000);
        acc(1'b0, 5'h01, anr_pkg::ADDR_LOCAL_ADV_UPPER, 16'h0000);
        chk({15'h0000, vld}, 16'h0000);
        rdc(anr_pkg::ADDR_LOCAL_ADV_UPPER, 16'h3000);
        acc(1'b1, anr_pkg::DEVAD_AN, anr_pkg::ADDR_PARTNER_LOWER, 16'hffff);
        rdc(anr_pkg::ADDR_PARTNER_LOWER, 16'h0000);
        acc(1'b1, anr_pkg::DEVAD_AN, anr_pkg::ADDR_LOCAL_ADV_UPPER, 16'h1000);
        rdc(anr_pkg::ADDR_LOCAL_ADV_UPPER, 16'h1000);
        $display("test write done");
    endtask : t_write

    task automatic t_level();
        logic [3:0] k;
        logic exp_lvl;
        for (int i = 0; i < 16; i++)
        begin
            k = i[3:0];
            acc(1'b1, anr_pkg::DEVAD_AN, anr_pkg::ADDR_LOCAL_ADV_UPPER, {2'h0, k[3:2], 12'h000});
            pg_hi = {2'h0, k[1:0], 12'h000};
            exp_lvl = k[3] & k[1] & (k[2] | k[0]);
            repeat (3) @(negedge clk_sys);
            chk({15'h0000, txh}, {15'h0000, exp_lvl});
        end
        $display("test level done");
    endtask : t_level

    task automatic t_page();
        pg_lo = 16'ha8ff;
        pg_mid = 16'h0010;
        pg_hi = 16'h3000;
        repeat (2) @(negedge clk_sys);
        rdc(anr_pkg::ADDR_PARTNER_LOWER, 16'ha800);
        pg_lo = 16'h57ff;
        pg_ok = 1'b1;
        repeat (2) @(negedge clk_sys);
        rdc(anr_pkg::ADDR_PARTNER_LOWER, 16'h5401);
        pg_mid = 16'h0000;
        pg_hi = 16'h0000;
        repeat (2) @(negedge clk_sys);
        rdc(anr_pkg::ADDR_PARTNER_MIDDLE, 16'h0010);
        rdc(anr_pkg::ADDR_PARTNER_HIGH, 16'h3000);
        rdc(anr_pkg::ADDR_PARTNER_LOWER, 16'h5401);
        rdc(anr_pkg::ADDR_PARTNER_MIDDLE, 16'h0000);
        $display("test page done");
    endtask : t_page

    task automatic t_strap();
        pg_mid = 16'h0010;
        repeat (2) @(negedge clk_sys);
        rdc(anr_pkg::ADDR_PARTNER_LOWER, 16'h5401);
        rst_n = 1'b0;
        s_cap = 1'b0;
        s_req = 1'b1;
        @(negedge clk_sys);
        chk({13'h0000, lc, lr, txh}, 16'h0000);
        chk(rdata, 16'h0000);
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        chk({14'h0000, lc, lr}, 16'h0001);
        rdc(anr_pkg::ADDR_LOCAL_ADV_UPPER, 16'h1000);
        rdc(anr_pkg::ADDR_PARTNER_MIDDLE, 16'h0000);
        $display("test strap done");
    endtask : t_strap

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        {rst_n, wr, rd, s_req, pg_ok, vld} = 6'h00;
        s_cap = 1'b1;
        devad = 5'h00;
        {addr, wdata, pg_lo, pg_mid, pg_hi, got} = 96'h0;
        fails = 0;
        n_tests = 0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        t_reset();
        t_write();
        t_level();
        t_page();
        t_strap();
        close_out();
    end
endmodule : tb_anr_ability_regs
